// >>> core/sbs_pkg.sv
// shared constants for the synchronous burst sram port
package sbs_pkg;
  // ---------------------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------------------
  localparam int ADDR_W    = 19;  // word address width
  localparam int DATA_W    = 32;  // data lanes, parity excluded
  localparam int LANE_NUM  = 4;   // byte lanes, one parity line each
  localparam int BURST_W   = 2;   // burst counter width
  // ---------------------------------------------------------------------------
  // reset values, burst step and lane masks
  // ---------------------------------------------------------------------------
  localparam logic       RST_STRAP_IL = 1'b1;   // strap pulled up: interleaved
  localparam logic       RST_SYNC_HI  = 1'b1;   // output enable idles inactive
  localparam logic       RST_SYNC_LO  = 1'b0;   // sleep idles inactive
  localparam logic [1:0] RST_BURST    = 2'h0;
  localparam logic [1:0] BURST_STEP   = 2'h1;
  localparam logic [3:0] LANES_ALL    = 4'hF;
  localparam logic [3:0] LANES_NONE   = 4'h0;
endpackage

// >>> core/sbs_burst_if.sv
// carrier between the port logic and its burst counter
`timescale 1ns/1ps
`default_nettype none
interface sbs_burst_if;
  logic       load;        // strobe accepted: restart burst
  logic [1:0] start_bits;  // low address bits at the strobe
  logic       advance;     // step the burst by one
  logic       interleave;  // order select from the strap
  logic [1:0] cur_bits;    // low address bits of the current beat
  logic [1:0] nxt_bits;    // low address bits of the following beat
  modport port (output load, start_bits, advance, interleave,
                input cur_bits, nxt_bits);
  modport ctr  (input load, start_bits, advance, interleave,
                output cur_bits, nxt_bits);
endinterface
`default_nettype wire

// >>> core/sbs_burst_ctr.sv
// two-bit burst counter, linear or interleaved order
`timescale 1ns/1ps
`default_nettype none
module sbs_burst_ctr (
  input  wire logic ref_clk,
  input  wire logic resetn,
  sbs_burst_if.ctr  bif
);
  logic [1:0] start_q;
  logic [1:0] count_q;

  // ---------------------------------------------------------------------------
  // order arithmetic
  // ---------------------------------------------------------------------------
  // one function serves current and following beat
  function automatic logic [1:0] sbs_order(input logic [1:0] s,
                                           input logic [1:0] c,
                                           input logic       il);
    sbs_order = il ? (s ^ c) : 2'(s + c);
  endfunction

  assign bif.cur_bits = sbs_order(start_q, count_q, bif.interleave);
  assign bif.nxt_bits = sbs_order(start_q, 2'(count_q + sbs_pkg::BURST_STEP),
                                  bif.interleave);

  // ---------------------------------------------------------------------------
  // counter state
  // ---------------------------------------------------------------------------
  // wraps modulo four; a strobe always wins over an advance
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      start_q <= sbs_pkg::RST_BURST;
      count_q <= sbs_pkg::RST_BURST;
    end else if (bif.load) begin
      start_q <= bif.start_bits;
      count_q <= sbs_pkg::RST_BURST;
    end else if (bif.advance) begin
      count_q <= 2'(count_q + sbs_pkg::BURST_STEP);
    end
  end

  a_load_start: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    bif.load |=> bif.cur_bits == $past(bif.start_bits))
    else $error("burst start not loaded");
  a_linear_step: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !bif.load && bif.advance && !bif.interleave && !$past(bif.interleave)
    |=> bif.cur_bits == 2'($past(bif.cur_bits) + 2'h1))
    else $error("linear burst step wrong");
  a_inter_step: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    bif.load ##1 (bif.advance && bif.interleave && !bif.load)
    |=> bif.cur_bits == ($past(bif.start_bits, 2) ^ 2'h1))
    else $error("interleaved burst step wrong");
endmodule
`default_nettype wire

// >>> core/sbs_port.sv
// pin-level behaviour of a flow-through burst sram with its array
// Function
// - controller strobe low captures address
// - strobe loads low address bits into counter
// - processor strobe wins over controller strobe
// - sleep: low power, array kept intact
// - sleep low or floating means normal operation
// - input data registered on rising edge
// - read drives data of previously addressed location
// - output enable low drives, high floats lines
// - first cycle after deselect keeps outputs floating
// - deselected device never drives data lines
// - parity lines follow their byte lane selects
// - strap low selects linear burst order
// - strap high or open selects interleaved order
// - global write updates all lanes
// - lane selects with enable pick written lanes
// - advance steps the burst counter
`timescale 1ns/1ps
`default_nettype none
module sbs_port #(
  parameter int ADDR_W   = sbs_pkg::ADDR_W,
  parameter int DATA_W   = sbs_pkg::DATA_W,
  parameter int LANE_NUM = sbs_pkg::LANE_NUM
) (
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic                chip_en1_n,
  input  wire logic                chip_en2,
  input  wire logic                chip_en3_n,
  input  wire logic                processor_addr_strobe_n,
  input  wire logic                controller_addr_strobe_n,
  input  wire logic                burst_advance_n,
  input  wire logic                global_write_n,
  input  wire logic                byte_write_enable_n,
  input  wire logic [LANE_NUM-1:0] byte_lane_select_n,
  input  wire logic                output_enable_n,
  input  wire logic                sleep_request,
  input  wire logic                burst_order_strap,
  input  wire logic [DATA_W-1:0]   dq_in,
  output logic      [DATA_W-1:0]   dq_out,
  output logic                     dq_oe,
  input  wire logic [LANE_NUM-1:0] parity_lines_in,
  output logic      [LANE_NUM-1:0] parity_lines_out,
  output logic      [LANE_NUM-1:0] parity_lines_oe
);
  localparam int LANE_W = DATA_W / LANE_NUM;

  // elaboration refuses geometry that the lane slicing cannot serve
  if (LANE_NUM != sbs_pkg::LANE_NUM || DATA_W % LANE_NUM != 0 ||
      ADDR_W < sbs_pkg::BURST_W + 1) begin : g_bad_geometry
    $error("sbs_port: unsupported geometry");
  end

  // ---------------------------------------------------------------------------
  // asynchronous pins: two flops before use
  // ---------------------------------------------------------------------------
  logic oe_n_s1, oe_n_s2, sleep_s1, sleep_s2, strap_s1, strap_s2;

  // output enable and sleep are asynchronous, strap is static
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      oe_n_s1  <= sbs_pkg::RST_SYNC_HI;
      oe_n_s2  <= sbs_pkg::RST_SYNC_HI;
      sleep_s1 <= sbs_pkg::RST_SYNC_LO;
      sleep_s2 <= sbs_pkg::RST_SYNC_LO;
      strap_s1 <= sbs_pkg::RST_STRAP_IL;
      strap_s2 <= sbs_pkg::RST_STRAP_IL;
    end else begin
      oe_n_s1  <= output_enable_n;
      oe_n_s2  <= oe_n_s1;
      sleep_s1 <= sleep_request;
      sleep_s2 <= sleep_s1;
      strap_s1 <= burst_order_strap;
      strap_s2 <= strap_s1;
    end
  end

  // ---------------------------------------------------------------------------
  // strobe decode
  // ---------------------------------------------------------------------------
  logic                 chip_sel, proc_ok, ctrl_ok, strobe, cont;
  logic [LANE_NUM-1:0]  lane_mask;
  logic [ADDR_W-1:0]    eff_addr;
  logic                 sel_q, first_q;
  logic [ADDR_W-1:0]    addr_q;
  sbs_burst_if          bif ();

  // in sleep every synchronous input is ignored
  assign chip_sel = !chip_en1_n && chip_en2 && !chip_en3_n;
  assign proc_ok  = !sleep_s2 && !processor_addr_strobe_n && !chip_en1_n;
  assign ctrl_ok  = !sleep_s2 && !controller_addr_strobe_n && !proc_ok;
  assign strobe   = proc_ok || ctrl_ok;
  assign cont     = !sleep_s2 && !strobe && sel_q;

  // global write overrides lane selects; strap-free write decode
  always_comb begin
    if (!global_write_n)
      lane_mask = sbs_pkg::LANES_ALL;
    else if (!byte_write_enable_n)
      lane_mask = ~byte_lane_select_n;
    else
      lane_mask = sbs_pkg::LANES_NONE;
  end

  // burst counter hookup
  assign bif.load       = strobe && chip_sel;
  assign bif.start_bits = addr[1:0];
  assign bif.advance    = cont && !burst_advance_n;
  assign bif.interleave = strap_s2;

  always_comb begin
    if (strobe)
      eff_addr = addr;
    else if (bif.advance)
      eff_addr = {addr_q[ADDR_W-1:2], bif.nxt_bits};
    else
      eff_addr = {addr_q[ADDR_W-1:2], bif.cur_bits};
  end

  sbs_burst_ctr u_ctr (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .bif     (bif)
  );

  // ---------------------------------------------------------------------------
  // selection state
  // ---------------------------------------------------------------------------
  // a strobe with chip enables inactive deselects the device
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sel_q   <= 1'b0;
      first_q <= 1'b0;
      addr_q  <= '0;
    end else if (strobe) begin
      sel_q   <= chip_sel;
      first_q <= chip_sel && !sel_q;
      if (chip_sel)
        addr_q <= addr;
    end else begin
      first_q <= 1'b0;
      addr_q  <= eff_addr;
    end
  end

  // ---------------------------------------------------------------------------
  // write path: register, then commit inside the next cycle
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0]   din_q;
  logic [LANE_NUM-1:0] par_q, wr_mask_q;
  logic [ADDR_W-1:0]   wr_addr_q;

  // processor-strobe cycles are always reads
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      din_q     <= '0;
      par_q     <= '0;
      wr_mask_q <= sbs_pkg::LANES_NONE;
      wr_addr_q <= '0;
    end else begin
      din_q     <= dq_in;
      par_q     <= parity_lines_in;
      wr_addr_q <= eff_addr;
      if ((ctrl_ok && chip_sel) || cont)
        wr_mask_q <= lane_mask;
      else
        wr_mask_q <= sbs_pkg::LANES_NONE;
    end
  end

  // array has no reset, so its contents survive sleep and reset alike
  logic [DATA_W-1:0]   mem     [2**ADDR_W];
  logic [LANE_NUM-1:0] mem_par [2**ADDR_W];

  always_ff @(posedge ref_clk) begin
    for (int l = 0; l < LANE_NUM; l++) begin
      if (wr_mask_q[l]) begin
        mem[wr_addr_q][l*LANE_W +: LANE_W] <= din_q[l*LANE_W +: LANE_W];
        mem_par[wr_addr_q][l] <= par_q[l];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0]   rd_q;
  logic [LANE_NUM-1:0] rdp_q;

  // a write still committing to the same word is not forwarded
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_q  <= '0;
      rdp_q <= '0;
    end else begin
      rd_q  <= mem[eff_addr];
      rdp_q <= mem_par[eff_addr];
    end
  end

  assign dq_out           = rd_q;
  assign parity_lines_out = rdp_q;
  // enable is two flops late: the price of synchronising the pin
  assign dq_oe = !oe_n_s2 && sel_q && !first_q && !sleep_s2;
  assign parity_lines_oe = {LANE_NUM{dq_oe}};

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_strobe_priority: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    proc_ok && !controller_addr_strobe_n |=> wr_mask_q == 4'h0)
    else $error("controller strobe honoured over processor strobe");
  a_first_hiz: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (strobe && chip_sel && !sel_q) |=> !dq_oe)
    else $error("outputs driven on first cycle after deselect");
  a_desel_hiz: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (strobe && !chip_sel) |=> !dq_oe && !(|parity_lines_oe))
    else $error("deselected device drives lines");
  // strobe writes and continue writes alike must take every lane
  a_global_write: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    ((ctrl_ok && chip_sel) || cont) && !global_write_n
    |=> wr_mask_q == 4'hF)
    else $error("global write missed a lane");
  // drive is judged in the sleep cycle itself: sleep may end at the next edge
  a_sleep_nowrite: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    sleep_s2 |-> (!dq_oe && !(|parity_lines_oe)) ##1 (wr_mask_q == 4'h0))
    else $error("activity during sleep");
endmodule
`default_nettype wire

// >>> dv/sbs_host_model.sv
// host side: write-control encoder and resolved data wire
`timescale 1ns/1ps
`default_nettype none
module sbs_host_model (
  input  wire logic        ref_clk,
  input  wire logic        wr_all,
  input  wire logic [3:0]  wr_lanes,
  input  wire logic [35:0] wr_data,
  input  wire logic [35:0] dev_data,
  input  wire logic        dev_oe,
  output logic             global_write_n,
  output logic             byte_write_enable_n,
  output logic [3:0]       byte_lane_select_n,
  output logic [35:0]      bus
);
  logic [35:0] last_q = 36'h0;
  logic        drv;
  // lane writes always carry the enable together with their selects
  assign byte_write_enable_n = ~|wr_lanes;
  assign byte_lane_select_n  = ~wr_lanes;
  assign global_write_n      = ~wr_all;
  assign drv = wr_all | (|wr_lanes);
  // a released wire flips every cycle so stale data never looks valid
  assign bus = dev_oe ? dev_data : (drv ? wr_data : ~last_q);
  always_ff @(posedge ref_clk) begin
    last_q <= bus;
  end
endmodule
`default_nettype wire

// >>> dv/tb_sync_burst_sram_port.sv
// self-checking bench for the burst sram port
`timescale 1ns/1ps
`default_nettype none
module tb_sync_burst_sram_port;
  logic        ref_clk, resetn, chip_en1_n, chip_en2, chip_en3_n;
  logic        processor_addr_strobe_n, controller_addr_strobe_n;
  logic        burst_advance_n, global_write_n, byte_write_enable_n;
  logic        output_enable_n, sleep_request, burst_order_strap;
  logic [18:0] addr;
  logic [3:0]  byte_lane_select_n, parity_lines_out, parity_lines_oe;
  logic [31:0] dq_out;
  logic        dq_oe, wr_all;
  logic [3:0]  wr_lanes;
  logic [35:0] wr_data, bus;
  logic [35:0] mem [256];
  integer      seed = 32'h7E49;
  int          err_count = 0;
  int          samples_checked = 0;

  sbs_port sbs_port_inst (.ref_clk(ref_clk), .resetn(resetn),
    .addr(addr), .chip_en1_n(chip_en1_n), .chip_en2(chip_en2),
    .chip_en3_n(chip_en3_n),
    .processor_addr_strobe_n(processor_addr_strobe_n),
    .controller_addr_strobe_n(controller_addr_strobe_n),
    .burst_advance_n(burst_advance_n), .global_write_n(global_write_n),
    .byte_write_enable_n(byte_write_enable_n),
    .byte_lane_select_n(byte_lane_select_n),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request),
    .burst_order_strap(burst_order_strap), .dq_in(bus[31:0]),
    .dq_out(dq_out), .dq_oe(dq_oe), .parity_lines_in(bus[35:32]),
    .parity_lines_out(parity_lines_out),
    .parity_lines_oe(parity_lines_oe));

  sbs_host_model sbs_host_model_inst (.ref_clk(ref_clk),
    .wr_all(wr_all), .wr_lanes(wr_lanes), .wr_data(wr_data),
    .dev_data({parity_lines_out, dq_out}), .dev_oe(dq_oe),
    .global_write_n(global_write_n),
    .byte_write_enable_n(byte_write_enable_n),
    .byte_lane_select_n(byte_lane_select_n), .bus(bus));

  // free-running 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // expected word after a write: selected lanes and their parity bits
  function automatic logic [35:0] merge(input logic [35:0] o, d,
                                        input logic g,
                                        input logic [3:0] ln);
    merge = o;
    for (int l = 0; l < 4; l++) begin
      if (g | ln[l]) begin
        merge[8*l +: 8] = d[8*l +: 8];
        merge[32+l]     = d[32+l];
      end
    end
  endfunction

  // expected low address bits of burst beat k
  function automatic logic [1:0] bo(input logic s,
                                    input logic [1:0] st, k);
    bo = s ? (st ^ k) : (st + k);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task automatic chk(input logic [35:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // strap only moves while reset is held, so the device sees it static
  task automatic rst(input logic s);
    resetn = 1'b0;
    burst_order_strap = s;
    cyc(16);
    resetn = 1'b1;
    output_enable_n = 1'b1;
    cyc(3);
  endtask

  task automatic oe_set(input logic v);
    output_enable_n = v;
    cyc(3);
  endtask

  task automatic strobe(input logic [18:0] a, input logic sel);
    addr = a;
    chip_en2 = sel;
    controller_addr_strobe_n = 1'b0;
    cyc(1);
    controller_addr_strobe_n = 1'b1;
    chip_en2 = 1'b1;
  endtask

  // write then one continue cycle for the commit edge
  task automatic wr(input logic [18:0] a, input logic g,
                    input logic [3:0] ln);
    wr_data = {4'($random(seed)), 32'($random(seed))};
    wr_all = g;
    wr_lanes = ln;
    strobe(a, 1'b1);
    wr_all = 1'b0;
    wr_lanes = 4'h0;
    mem[a[7:0]] = merge(mem[a[7:0]], wr_data, g, ln);
    cyc(1);
  endtask

  // a write the device must refuse: the model is left untouched
  task automatic bad_wr(input logic [18:0] a);
    wr_all = 1'b1;
    wr_data = ~mem[a[7:0]];
    strobe(a, 1'b1);
    wr_all = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [18:0] a);
    strobe(a, 1'b1);
    chk({parity_lines_out, dq_out}, mem[a[7:0]]);
  endtask

  task automatic burst(input logic s);
    logic [18:0] b;
    logic [1:0]  st;
    rst(s);
    b = 19'($random(seed) & 8'hF0) | 19'h10;
    st = 2'($random(seed));
    for (int k = 0; k < 4; k++) wr(b | 19'(k), 1'b1, 4'h0);
    oe_set(1'b0);
    rd(b | 19'(st));
    burst_advance_n = 1'b0;
    for (int k = 1; k < 4; k++) begin
      cyc(1);
      chk({parity_lines_out, dq_out},
          mem[b[7:0] | 8'(bo(s, st, 2'(k)))]);
    end
    burst_advance_n = 1'b1;
  endtask

  // main sequence
  initial begin
    {chip_en1_n, chip_en3_n, burst_advance_n} = 3'h1;
    {processor_addr_strobe_n, controller_addr_strobe_n} = 2'h3;
    {chip_en2, output_enable_n, sleep_request, wr_all} = 4'hC;
    {addr, wr_lanes, wr_data} = '0;
    rst(1'b0);
    for (int i = 0; i < 16; i++) wr(19'(i), 1'b1, 4'h0);
    repeat (24) wr(19'($random(seed) & 15), ($random(seed) & 7) == 0,
                   4'($random(seed)));
    oe_set(1'b0);
    // an idle edge between reads keeps the strobe from being re-driven
    for (int i = 0; i < 16; i++) begin
      rd(19'(i));
      cyc(1);
    end
    chk(36'({parity_lines_oe, dq_oe}), 36'h1F);
    strobe(19'h3, 1'b0);
    chk(36'({parity_lines_oe, dq_oe}), 36'h0);
    cyc(1);
    chk(36'({parity_lines_oe, dq_oe}), 36'h0);
    rd(19'h3);
    chk(36'(dq_oe), 36'h0);
    cyc(1);
    chk(36'(dq_oe), 36'h1);
    oe_set(1'b1);
    chk(36'({parity_lines_oe, dq_oe}), 36'h0);
    processor_addr_strobe_n = 1'b0;
    bad_wr(19'h5);
    processor_addr_strobe_n = 1'b1;
    sleep_request = 1'b1;
    cyc(3);
    bad_wr(19'h6);
    sleep_request = 1'b0;
    oe_set(1'b0);
    rd(19'h5);
    cyc(1);
    rd(19'h6);
    burst(1'b0);
    burst(1'b1);
    report_and_stop();
  end

  // watchdog: many times the few hundred cycles the run needs
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
